// ---- tld_top.sv ----
// Torque limit select and detect block with Avalon-MM register slave
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`include "tld_params.svh"

// How it works
// RULE1: The detect contact pair closes while the torque reference magnitude exceeds the active limit and opens otherwise.
// RULE2: Output function bit 4 at 0 drives the pair from limit detection, at 1 from speed coincidence.
// RULE3: The status indication bit and io monitor bit 4 always follow the state of the detect pair.
// RULE4: The active limit is the internal limit, plus each external limit only while its contact is asserted.
// RULE5: A low forward contact restricts forward torque to the forward external limit; high means normal operation.
// RULE6: A low reverse contact restricts reverse torque to the reverse external limit; high means normal operation.
// RULE7: Contact torque limiting works only while speed control select bit 2 is 0.
// RULE8: With speed control select bit 2 at 1 the two contacts are decoded as a speed selection instead.
// RULE9: External limits are percent settings clamped to maximum torque, resetting to 100.
// RULE10: All limits are percent of rated torque and internal limits reset to maximum torque.
// RULE11: When both an internal and an applied external limit exist, the smaller one is used.
module tld_top
    import tld_pkg::*;
#(
    parameter int LIM_W = `TLD_LIM_W_DEF,
    parameter int TRQ_W = `TLD_TRQ_W_DEF,
    parameter logic [LIM_W-1:0] MAX_TORQUE = LIM_W'(`TLD_MAX_TORQUE_DEF)
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Drive internals on the same clock
    input wire logic signed [TRQ_W-1:0] torque_ref_i,
    input wire logic speed_coin_i,
    // Contact input pins, active low
    input wire logic fwd_ext_limit_in_n_i,
    input wire logic rev_ext_limit_in_n_i,
    // Contact output pair, low while closed
    output logic limit_detect_out_a_o,
    output logic limit_detect_out_b_o,
    // Limits handed to the current loop and speed selection
    output logic [LIM_W-1:0] torque_limit_fwd_o,
    output logic [LIM_W-1:0] torque_limit_rev_o,
    output tld_spd_sel_t speed_select_o,
    // Interrupt, level
    output logic irq_o
);
    // Settings
    logic output_function_switch;
    logic speed_control_switch;
    logic [LIM_W-1:0] fwd_internal_limit_value;
    logic [LIM_W-1:0] rev_internal_limit_value;
    logic [LIM_W-1:0] fwd_external_limit_value;
    logic [LIM_W-1:0] rev_external_limit_value;
    logic [`TLD_ST_W-1:0] irq_status;
    logic [`TLD_ST_W-1:0] irq_mask;

    // Pin side
    logic [1:0] pins_sync;
    logic fwd_ext_limit_in;
    logic rev_ext_limit_in;
    logic fwd_ext_on;
    logic rev_ext_on;
    logic [LIM_W-1:0] fwd_eff;
    logic [LIM_W-1:0] rev_eff;
    logic over;
    logic detect_closed;
    logic next_closed;
    logic fwd_in_q;
    logic rev_in_q;

    // Bus side
    logic bus_req;
    logic bus_commit;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] next_rdata;
    logic [LIM_W-1:0] wr_lim;
    logic [`TLD_ST_W-1:0] events;
    logic [31:0] io_monitor_word;

    tld_sync #(
        .W(2)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i({rev_ext_limit_in_n_i, fwd_ext_limit_in_n_i}),
        .sync_o(pins_sync)
    );

    // Contacts are asserted at low level
    assign fwd_ext_limit_in = ~pins_sync[0];
    assign rev_ext_limit_in = ~pins_sync[1];
    // Contact limiting only while speed selection is off
    assign fwd_ext_on = fwd_ext_limit_in && !speed_control_switch; // RULE7 RULE5
    assign rev_ext_on = rev_ext_limit_in && !speed_control_switch; // RULE7 RULE6

    tld_limit_sel #(
        .LIM_W(LIM_W),
        .TRQ_W(TRQ_W)
    ) u_sel (
        .torque_ref_i(torque_ref_i),
        .fwd_int_i(fwd_internal_limit_value),
        .rev_int_i(rev_internal_limit_value),
        .fwd_ext_i(fwd_external_limit_value),
        .rev_ext_i(rev_external_limit_value),
        .fwd_ext_on_i(fwd_ext_on),
        .rev_ext_on_i(rev_ext_on),
        .fwd_eff_o(fwd_eff),
        .rev_eff_o(rev_eff),
        .over_o(over)
    );

    // Output function chooses the source of the contact pair
    assign next_closed = output_function_switch ? speed_coin_i : over; // RULE2

    // Contact pair state and its pins; both pins low while closed
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            detect_closed <= 1'b0;
            limit_detect_out_a_o <= 1'b1;
            limit_detect_out_b_o <= 1'b1;
        end else begin
            detect_closed <= next_closed; // RULE1 RULE2
            limit_detect_out_a_o <= ~next_closed; // RULE1
            limit_detect_out_b_o <= ~next_closed; // RULE1
        end
    end

    // Limits for the current loop, registered to keep outputs glitch free
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            torque_limit_fwd_o <= MAX_TORQUE;
            torque_limit_rev_o <= MAX_TORQUE;
        end else begin
            torque_limit_fwd_o <= fwd_eff; // RULE5 RULE11
            torque_limit_rev_o <= rev_eff; // RULE6 RULE11
        end
    end

    // Speed selection decode; normal code whenever contact limiting is in use
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            speed_select_o <= TLD_SPD_NORMAL;
        end else if (speed_control_switch) begin
            speed_select_o <= tld_spd_sel_t'({fwd_ext_limit_in, rev_ext_limit_in}); // RULE8
        end else begin
            speed_select_o <= TLD_SPD_NORMAL;
        end
    end

    // Previous input levels for change events
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fwd_in_q <= 1'b0;
            rev_in_q <= 1'b0;
        end else begin
            fwd_in_q <= fwd_ext_limit_in;
            rev_in_q <= rev_ext_limit_in;
        end
    end

    // Events: pair closes, pair opens, either contact changes
    always_comb begin
        events = '0;
        events[`TLD_ST_DET_ON_BIT] = next_closed && !detect_closed;
        events[`TLD_ST_DET_OFF_BIT] = !next_closed && detect_closed;
        events[`TLD_ST_FWD_IN_BIT] = fwd_ext_limit_in != fwd_in_q;
        events[`TLD_ST_REV_IN_BIT] = rev_ext_limit_in != rev_in_q;
    end

    // Monitor word mirrors the pair and the two contacts, read only
    always_comb begin
        io_monitor_word = '0;
        io_monitor_word[`TLD_MON_DETECT_BIT] = detect_closed; // RULE3
        io_monitor_word[`TLD_MON_FWD_IN_BIT] = fwd_ext_limit_in;
        io_monitor_word[`TLD_MON_REV_IN_BIT] = rev_ext_limit_in;
    end

    // One wait cycle per access: commit on the edge that sees waitrequest low
    assign bus_req = avs_read_i || avs_write_i;
    assign bus_commit = bus_req && !avs_waitrequest_o;
    assign bus_wr = bus_commit && avs_write_i;
    assign bus_rd = bus_commit && avs_read_i;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        unique case (avs_address_i)
            `TLD_OFF_OUT_FUNC: next_rdata[`TLD_OUT_FUNC_BIT] = output_function_switch;
            `TLD_OFF_SPD_CTRL: next_rdata[`TLD_SPD_CTRL_BIT] = speed_control_switch;
            `TLD_OFF_FWD_INT: next_rdata[LIM_W-1:0] = fwd_internal_limit_value;
            `TLD_OFF_REV_INT: next_rdata[LIM_W-1:0] = rev_internal_limit_value;
            `TLD_OFF_FWD_EXT: next_rdata[LIM_W-1:0] = fwd_external_limit_value;
            `TLD_OFF_REV_EXT: next_rdata[LIM_W-1:0] = rev_external_limit_value;
            `TLD_OFF_IO_MON: next_rdata = io_monitor_word; // RULE3
            `TLD_OFF_STATUS: next_rdata[`TLD_ST_W-1:0] = irq_status;
            `TLD_OFF_IRQ_MASK: next_rdata[`TLD_ST_W-1:0] = irq_mask;
            `TLD_OFF_STAT_IND: next_rdata[0] = detect_closed; // RULE3
            default: next_rdata = '0;
        endcase
    end

    // Read data is captured in the answer cycle and holds through the commit edge
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= '0;
        end else if (bus_req && avs_waitrequest_o && avs_read_i) begin
            avs_readdata_o <= next_rdata;
        end
    end

    // Writes above maximum torque are clamped to it
    assign wr_lim = (avs_writedata_i > 32'(MAX_TORQUE)) ? MAX_TORQUE : avs_writedata_i[LIM_W-1:0]; // RULE9 RULE10

    // Switch bits
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            output_function_switch <= 1'b0;
            speed_control_switch <= 1'b0;
        end else if (bus_wr) begin
            if (avs_address_i == `TLD_OFF_OUT_FUNC) begin
                output_function_switch <= avs_writedata_i[`TLD_OUT_FUNC_BIT];
            end
            if (avs_address_i == `TLD_OFF_SPD_CTRL) begin
                speed_control_switch <= avs_writedata_i[`TLD_SPD_CTRL_BIT];
            end
        end
    end

    // Limit settings in percent of rated torque
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fwd_internal_limit_value <= MAX_TORQUE; // RULE10
            rev_internal_limit_value <= MAX_TORQUE; // RULE10
            fwd_external_limit_value <= LIM_W'(`TLD_EXT_LIM_RST); // RULE9
            rev_external_limit_value <= LIM_W'(`TLD_EXT_LIM_RST); // RULE9
        end else if (bus_wr) begin
            unique case (avs_address_i)
                `TLD_OFF_FWD_INT: fwd_internal_limit_value <= wr_lim;
                `TLD_OFF_REV_INT: rev_internal_limit_value <= wr_lim;
                `TLD_OFF_FWD_EXT: fwd_external_limit_value <= wr_lim;
                `TLD_OFF_REV_EXT: rev_external_limit_value <= wr_lim;
                default: ;
            endcase
        end
    end

    // Sticky status; a read clears it, but a new event in that cycle survives
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else if (bus_rd && avs_address_i == `TLD_OFF_STATUS) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // Mask register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_mask <= '0;
        end else if (bus_wr && avs_address_i == `TLD_OFF_IRQ_MASK) begin
            irq_mask <= avs_writedata_i[`TLD_ST_W-1:0];
        end
    end

    // Interrupt level, one cycle behind the status
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // Checks on the guarded logic
    a_detect_close: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE1
        !output_function_switch ##1 !$past(output_function_switch) |-> detect_closed == $past(over))
        else $error("detect pair does not follow over-limit compare");
    a_coin_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE2
        output_function_switch && speed_coin_i |=> detect_closed)
        else $error("speed coincidence not on pair");
    a_monitor_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE3
        io_monitor_word[`TLD_MON_DETECT_BIT] == detect_closed && limit_detect_out_b_o == !detect_closed)
        else $error("monitor bit differs from pair");
    a_int_only: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE4
        !fwd_ext_on |-> fwd_eff == fwd_internal_limit_value)
        else $error("external limit applied without contact");
    a_fwd_ext: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE5
        fwd_ext_on && fwd_external_limit_value < fwd_internal_limit_value |=> torque_limit_fwd_o
            == $past(fwd_external_limit_value))
        else $error("forward contact limit not applied");
    a_rev_ext: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE6
        rev_ext_on && rev_external_limit_value < rev_internal_limit_value |=> torque_limit_rev_o
            == $past(rev_external_limit_value))
        else $error("reverse contact limit not applied");
    a_spd_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE7
        speed_control_switch |-> !fwd_ext_on && !rev_ext_on)
        else $error("contact limiting active in speed select mode");
    a_spd_decode: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE8
        speed_control_switch && fwd_ext_limit_in && !rev_ext_limit_in |=> speed_select_o == TLD_SPD_THREE)
        else $error("speed selection decode wrong");
    a_ext_reset: assert property (@(posedge ref_clk_i) // RULE9 RULE10
        $fell(rst_i) |-> fwd_external_limit_value == LIM_W'(`TLD_EXT_LIM_RST)
            && rev_internal_limit_value == MAX_TORQUE)
        else $error("limit reset values wrong");
    a_min_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE11
        rev_eff <= rev_internal_limit_value && fwd_eff <= fwd_internal_limit_value)
        else $error("effective limit above internal limit");
    a_rev_int_only: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE4
        !rev_ext_on |-> rev_eff == rev_internal_limit_value)
        else $error("reverse external limit applied without contact");
    a_over_close: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE1
        !output_function_switch && over |=> !limit_detect_out_a_o && !limit_detect_out_b_o)
        else $error("pair not closed while over the limit");
    a_under_open: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE1
        !output_function_switch && !over |=> limit_detect_out_a_o && limit_detect_out_b_o)
        else $error("pair not open while at or below the limit");
    a_coin_open: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE2
        output_function_switch && !speed_coin_i |=> !detect_closed)
        else $error("pair closed without speed coincidence");
    a_close_event: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE3
        next_closed && !detect_closed |=> irq_status[`TLD_ST_DET_ON_BIT])
        else $error("pair closing not recorded in status");
    a_spd_normal: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE7
        !speed_control_switch |=> speed_select_o == TLD_SPD_NORMAL)
        else $error("speed selection active in torque limit mode");
    // Clamping on write keeps every setting inside the usable range
    a_lim_range: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE9 RULE10
        fwd_internal_limit_value <= MAX_TORQUE && rev_internal_limit_value <= MAX_TORQUE
            && fwd_external_limit_value <= MAX_TORQUE && rev_external_limit_value <= MAX_TORQUE)
        else $error("limit setting above maximum torque");
endmodule

// ---- tld_params.svh ----
// Offsets, field positions, reset values and sizes of the torque limit detect block
`ifndef TLD_PARAMS_SVH
`define TLD_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define TLD_OFF_OUT_FUNC 8'h00
`define TLD_OFF_SPD_CTRL 8'h04
`define TLD_OFF_FWD_INT 8'h08
`define TLD_OFF_REV_INT 8'h0C
`define TLD_OFF_FWD_EXT 8'h10
`define TLD_OFF_REV_EXT 8'h14
`define TLD_OFF_IO_MON 8'h18
`define TLD_OFF_STATUS 8'h1C
`define TLD_OFF_IRQ_MASK 8'h20
`define TLD_OFF_STAT_IND 8'h24

// Field positions and status width
`define TLD_OUT_FUNC_BIT 4
`define TLD_SPD_CTRL_BIT 2
`define TLD_MON_DETECT_BIT 4
`define TLD_MON_FWD_IN_BIT 7
`define TLD_MON_REV_IN_BIT 8
`define TLD_ST_DET_ON_BIT 0
`define TLD_ST_DET_OFF_BIT 1
`define TLD_ST_FWD_IN_BIT 2
`define TLD_ST_REV_IN_BIT 3
`define TLD_ST_W 4

// Reset values and default widths
`define TLD_EXT_LIM_RST 100
`define TLD_MAX_TORQUE_DEF 300
`define TLD_LIM_W_DEF 10
`define TLD_TRQ_W_DEF 12

`endif

// ---- tld_pkg.sv ----
// Types shared by the torque limit detect block
package tld_pkg;

    // Speed selection decoded from the two contact inputs (forward, reverse)
    typedef enum logic [1:0] {
        TLD_SPD_NORMAL = 2'b00,
        TLD_SPD_ONE = 2'b01,
        TLD_SPD_TWO = 2'b11,
        TLD_SPD_THREE = 2'b10
    } tld_spd_sel_t;

endpackage

// ---- tld_sync.sv ----
// Two flip-flop synchroniser for contact input pins
`timescale 1ns/1ns
module tld_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Asynchronous pins and their synchronised copy
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage1;

    // Pins idle high (contact open), so both stages reset to ones
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            stage1 <= {W{1'b1}};
            sync_o <= {W{1'b1}};
        end else begin
            stage1 <= pin_i;
            sync_o <= stage1;
        end
    end
endmodule

// ---- tld_limit_sel.sv ----
// Effective torque limit selection and over-limit comparison
`timescale 1ns/1ns
module tld_limit_sel #(
    parameter int LIM_W = 10,
    parameter int TRQ_W = 12
) (
    // Torque reference, signed percent of rated torque
    input wire logic signed [TRQ_W-1:0] torque_ref_i,
    // Limit settings in percent
    input wire logic [LIM_W-1:0] fwd_int_i,
    input wire logic [LIM_W-1:0] rev_int_i,
    input wire logic [LIM_W-1:0] fwd_ext_i,
    input wire logic [LIM_W-1:0] rev_ext_i,
    // Contact requests, already gated by the speed control switch
    input wire logic fwd_ext_on_i,
    input wire logic rev_ext_on_i,
    // Results
    output logic [LIM_W-1:0] fwd_eff_o,
    output logic [LIM_W-1:0] rev_eff_o,
    output logic over_o
);
    logic [TRQ_W-1:0] mag;
    logic [LIM_W-1:0] dir_lim;

    // Smaller of internal and applied external limit per direction
    always_comb begin
        fwd_eff_o = (fwd_ext_on_i && (fwd_ext_i < fwd_int_i)) ? fwd_ext_i : fwd_int_i; // RULE4 RULE5 RULE11
        rev_eff_o = (rev_ext_on_i && (rev_ext_i < rev_int_i)) ? rev_ext_i : rev_int_i; // RULE4 RULE6 RULE11
    end

    // Sign picks the direction; magnitude is compared strictly greater
    always_comb begin
        mag = torque_ref_i[TRQ_W-1] ? TRQ_W'(-torque_ref_i) : TRQ_W'(torque_ref_i);
        dir_lim = torque_ref_i[TRQ_W-1] ? rev_eff_o : fwd_eff_o;
        over_o = mag > {{(TRQ_W-LIM_W){1'b0}}, dir_lim}; // RULE1
    end
endmodule

// ---- tld_host.sv ----
// Host controller model: drives the two contact inputs and watches the detect pair
`timescale 1ns/1ns
module tld_host #(
    parameter int DLY = 1
) (
    // Clock
    input wire logic ref_clk_i,
    // Requests from the bench
    input wire logic fwd_on_i,
    input wire logic rev_on_i,
    // Detect contact pair from the drive
    input wire logic detect_a_i,
    input wire logic detect_b_i,
    // Contact pins, active low
    output logic fwd_ext_limit_in_n_o,
    output logic rev_ext_limit_in_n_o,
    // Pair seen closed
    output logic closed_o
);
    logic [DLY:0] fwd_pipe = '0;
    logic [DLY:0] rev_pipe = '0;

    // Relay delay of the host outputs, so pins never move on the bench's edge
    always_ff @(posedge ref_clk_i) begin
        fwd_pipe <= {fwd_pipe[DLY-1:0], fwd_on_i};
        rev_pipe <= {rev_pipe[DLY-1:0], rev_on_i};
    end

    // Pins pulled low while a limit is requested, high otherwise
    assign fwd_ext_limit_in_n_o = ~fwd_pipe[DLY];
    assign rev_ext_limit_in_n_o = ~rev_pipe[DLY];
    // Closed only when both contacts read low
    assign closed_o = ~detect_a_i & ~detect_b_i;
endmodule

// ---- tb_tld_top.sv ----
// Self-checking bench for the torque limit select and detect block
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %0h exp %0h", $time, a, e); end end
module tb_tld_top
    import tld_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic signed [11:0] torque_ref_i = 12'h000;
    logic speed_coin_i = 1'b0;
    logic fwd_on = 1'b0;
    logic rev_on = 1'b0;
    wire fwd_n;
    wire rev_n;
    wire closed;
    logic out_a;
    logic out_b;
    logic [9:0] lim_fwd;
    logic [9:0] lim_rev;
    tld_spd_sel_t spd;
    logic irq;
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] q;

    tld_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .torque_ref_i(torque_ref_i), .speed_coin_i(speed_coin_i),
        .fwd_ext_limit_in_n_i(fwd_n), .rev_ext_limit_in_n_i(rev_n), .limit_detect_out_a_o(out_a),
        .limit_detect_out_b_o(out_b), .torque_limit_fwd_o(lim_fwd), .torque_limit_rev_o(lim_rev),
        .speed_select_o(spd), .irq_o(irq));
    tld_host #(.DLY(1)) host (.ref_clk_i(ref_clk_i), .fwd_on_i(fwd_on), .rev_on_i(rev_on), .detect_a_i(out_a),
        .detect_b_i(out_b), .fwd_ext_limit_in_n_o(fwd_n), .rev_ext_limit_in_n_o(rev_n), .closed_o(closed));

    // 50 MHz clock
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // One bus cycle; the request holds until the rising edge that samples waitrequest low, data is taken there
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int t;
        t = 0;
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= ~w;
        do begin
            @(posedge ref_clk_i);
            t++;
        end while (avs_waitrequest_o !== 1'b0 && t < 100);
        if (t >= 100) n_errors++;
        r = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        repeat (3) @(posedge ref_clk_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask
    // Torque has one edge of latency; two more are margin
    task automatic trq(input logic signed [11:0] v);
        @(posedge ref_clk_i);
        torque_ref_i <= v;
        repeat (3) @(posedge ref_clk_i);
    endtask
    // Pins reach the limits three edges after they move, plus the host delay
    task automatic pins(input logic f, input logic r);
        @(posedge ref_clk_i);
        fwd_on <= f;
        rev_on <= r;
        repeat (6) @(posedge ref_clk_i);
    endtask
    task automatic pair(input logic c);
        `CHK({out_a, out_b, closed}, c ? 3'b001 : 3'b110)
    endtask

    task automatic t_reset;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h08, 32'h12C);
        rd_chk(8'h0C, 32'h12C);
        rd_chk(8'h10, 32'h64);
        rd_chk(8'h14, 32'h64);
        rd_chk(8'h24, 32'h0);
        `CHK(lim_fwd, 10'h12C)
        `CHK(spd, TLD_SPD_NORMAL)
        pair(1'b0);
    endtask
    // Settings above maximum torque are clamped
    task automatic t_clamp;
        wr(8'h08, 32'h3FF);
        rd_chk(8'h08, 32'h12C);
        wr(8'h10, 32'h3FF);
        rd_chk(8'h10, 32'h12C);
        wr(8'h08, 32'h32);
        wr(8'h0C, 32'h28);
    endtask
    // Equal to the limit stays open, one above closes, both signs
    task automatic t_detect;
        trq(12'sh032);
        pair(1'b0);
        trq(12'sh033);
        pair(1'b1);
        rd_chk(8'h18, 32'h10);
        rd_chk(8'h24, 32'h1);
        trq(-12'sh028);
        pair(1'b0);
        trq(-12'sh029);
        pair(1'b1);
        trq(12'sh000);
        rd_chk(8'h18, 32'h0);
    endtask
    task automatic t_ext;
        pins(1'b1, 1'b0);
        `CHK(lim_fwd, 10'h032)
        `CHK(lim_rev, 10'h028)
        rd_chk(8'h18, 32'h80);
        wr(8'h10, 32'h14);
        `CHK(lim_fwd, 10'h014)
        trq(12'sh015);
        pair(1'b1);
        trq(12'sh014);
        pair(1'b0);
        pins(1'b0, 1'b0);
        `CHK(lim_fwd, 10'h032)
        wr(8'h14, 32'h0A);
        pins(1'b0, 1'b1);
        `CHK(lim_rev, 10'h00A)
        `CHK(lim_fwd, 10'h032)
        trq(-12'sh00B);
        pair(1'b1);
        pins(1'b0, 1'b0);
        `CHK(lim_rev, 10'h028)
        pair(1'b0);
        trq(12'sh000);
    endtask
    // Speed mode: contacts select speeds and no longer limit torque
    task automatic t_speed;
        tld_spd_sel_t exp_sel [4];
        exp_sel = '{TLD_SPD_NORMAL, TLD_SPD_ONE, TLD_SPD_THREE, TLD_SPD_TWO};
        wr(8'h04, 32'h4);
        for (int i = 0; i < 4; i++) begin
            pins(i[1], i[0]);
            `CHK(spd, exp_sel[i])
            `CHK({lim_fwd, lim_rev}, {10'h032, 10'h028})
        end
        pins(1'b0, 1'b0);
        wr(8'h04, 32'h0);
        `CHK(spd, TLD_SPD_NORMAL)
    endtask
    // Bit 4 hands the pair to speed coincidence
    task automatic t_func;
        trq(12'sh03C);
        wr(8'h00, 32'h10);
        pair(1'b0);
        @(posedge ref_clk_i);
        speed_coin_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        pair(1'b1);
        rd_chk(8'h18, 32'h10);
        @(posedge ref_clk_i);
        speed_coin_i <= 1'b0;
        wr(8'h00, 32'h0);
        pair(1'b1);
        trq(12'sh000);
    endtask
    task automatic t_irq;
        bus(1'b0, 8'h1C, 32'h0, q);
        wr(8'h20, 32'h1);
        trq(12'sh03C);
        `CHK(irq, 1'b1)
        rd_chk(8'h1C, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        `CHK(irq, 1'b0)
        trq(12'sh000);
        `CHK(irq, 1'b0)
        rd_chk(8'h1C, 32'h2);
    endtask
    // Unmapped and read-only places
    task automatic t_bus;
        rd_chk(8'h40, 32'h0);
        wr(8'h18, 32'hFFFF);
        rd_chk(8'h18, 32'h0);
        wr(8'h24, 32'h1);
        rd_chk(8'h24, 32'h0);
    endtask

    task automatic results;
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_clamp();
        t_detect();
        t_ext();
        t_speed();
        t_func();
        t_irq();
        t_bus();
        results();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_errors++;
        results();
    end
endmodule
